// [core/rtcb_core.sv]
// Purpose: 16-bit real-time counter with prescaler, drift correction and apb registers
// Assumes: rtc clock pin is much slower than pclk; zero-wait apb slave
// Notes:   rtc edges are sampled, so the rtc domain is an enable, not a clock
`default_nettype none

module rtcb_core
    import rtcb_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    // rtc clock pin
    input  wire logic        rtc_clk_pin,
    // interrupt controller
    input  wire logic        wrap_vector_ack,
    input  wire logic        match_vector_ack,
    output logic             wrap_irq_req,
    output logic             match_irq_req,
    output logic      [1:0]  wrap_irq_level,
    output logic      [1:0]  match_irq_level,
    output logic      [7:0]  irq_vector,
    output logic             irq,
    // events
    output logic             wrap_event,
    output logic             match_event
);

    typedef struct packed {
        logic [2:0]    rsync;
        logic          rlev;
        logic [9:0]    presc;
        logic [19:0]   acc;
        logic [19:0]   ivl;
        logic          corr_act;
        logic [3:0]    ctrl;
        logic [15:0]   cnt;
        logic [15:0]   top;
        logic [15:0]   match;
        logic [3:0]    st_ctrl;
        logic [15:0]   st_cnt;
        logic [15:0]   st_top;
        logic [15:0]   st_match;
        logic [3:0]    pend;
        rtcb_sync_type sync;
        logic [7:0]    latch;
        logic [7:0]    drift_correction;
        logic [3:0]    ilvl;
        logic [1:0]    flags;
        logic [1:0]    mask;
        logic [31:0]   prdata;
        logic          pready;
        logic          irq;
        logic          wrap_req;
        logic          match_req;
        logic [7:0]    vec;
        logic          wrap_evt;
        logic          match_evt;
    } rtcb_state_type;

    rtcb_state_type r;
    rtcb_state_type n;

    logic        rtc_tick;
    logic        corr_slot;
    logic        cnt_tick;
    logic        wrap_hit;
    logic        match_hit;
    logic        sync_apply;
    logic        mapped;
    logic        rd_setup;
    logic        wr_edge;
    logic [3:0]  idx;
    logic [3:0]  shift;
    logic [1:0]  inc;
    logic [1:0]  clr;
    logic [7:0]  rd_byte;
    logic [7:0]  wd;
    logic [10:0] psum;
    logic [20:0] corr_sum;
    logic [15:0] top_view;
    logic [15:0] match_view;

    function automatic logic [3:0] div_shift(input logic [2:0] code);
        case (code)
            3'h1:    div_shift = 4'h0;
            3'h2:    div_shift = 4'h1;
            3'h3:    div_shift = 4'h3;
            3'h4:    div_shift = 4'h4;
            3'h5:    div_shift = 4'h6;
            3'h6:    div_shift = 4'h8;
            3'h7:    div_shift = 4'ha;
            default: div_shift = 4'h0;
        endcase
    endfunction

    always_comb begin
        n = r;
        // pin sampling: a level counts once the second and third stages agree
        n.rsync = {r.rsync[1:0], rtc_clk_pin};
        if (r.rsync[1] == r.rsync[2]) begin
            n.rlev = r.rsync[2];
        end
        rtc_tick = r.rsync[1] & r.rsync[2] & ~r.rlev;

        // drift correction: an accumulator spreads the corrections evenly
        corr_sum = {1'b0, r.acc} + {14'h0, r.drift_correction[6:0]};
        corr_slot = 1'b0;
        if (rtc_tick) begin
            if (r.corr_act) begin
                n.acc = corr_sum[19:0];
                corr_slot = corr_sum[CORR_BITS];
                n.ivl = r.ivl + 20'h1;
                if (&r.ivl) begin
                    n.corr_act = r.ctrl[CTRL_CORR_BIT];
                end
            end else if (r.ctrl[CTRL_CORR_BIT]) begin
                n.corr_act = 1'b1;
                n.acc = '0;
                n.ivl = '0;
            end
        end

        // prescaler; with divide-by-one an added cycle cannot be seen
        inc = 2'h1;
        if (corr_slot) begin
            inc = r.drift_correction[DRIFT_CORRECTION_SIGN_BIT] ? 2'h2 : 2'h0;
        end
        psum = {1'b0, r.presc} + {9'h0, inc};
        shift = div_shift(r.ctrl[2:0]);
        cnt_tick = 1'b0;
        if (rtc_tick && r.ctrl[2:0] != PRE_OFF) begin
            n.presc = psum[9:0];
            cnt_tick = (psum >> shift) != ({1'b0, r.presc} >> shift);
        end

        // counter and comparators
        wrap_hit = r.cnt == r.top;
        match_hit = (r.cnt == r.match) && (r.match <= r.top);
        n.wrap_evt = 1'b0;
        n.match_evt = 1'b0;
        if (cnt_tick) begin
            n.cnt = wrap_hit ? RST_WORD : r.cnt + 16'h1;
            n.wrap_evt = wrap_hit;
            n.match_evt = match_hit;
        end

        // write crossing: staged values land on the second rtc cycle
        sync_apply = 1'b0;
        case (r.sync)
            SYNC_IDLE: n.sync = SYNC_IDLE;
            SYNC_ARMED: begin
                if (rtc_tick) begin
                    n.sync = SYNC_HALF;
                end
            end
            SYNC_HALF: begin
                if (rtc_tick) begin
                    sync_apply = 1'b1;
                    n.sync = SYNC_IDLE;
                end
            end
            default: n.sync = SYNC_IDLE;
        endcase
        if (sync_apply) begin
            if (r.pend[0]) begin
                n.ctrl = r.st_ctrl;
            end
            if (r.pend[1]) begin
                n.cnt = r.st_cnt;
            end
            if (r.pend[2]) begin
                n.top = r.st_top;
            end
            if (r.pend[3]) begin
                n.match = r.st_match;
            end
            n.pend = '0;
        end

        // apb decode
        idx = paddr[5:2];
        mapped = paddr[7:6] == 2'h0;
        wd = pwdata[7:0];
        rd_setup = psel & ~penable & ~pwrite & mapped;
        wr_edge = psel & penable & r.pready & pwrite & mapped;
        top_view = r.pend[2] ? r.st_top : r.top;
        match_view = r.pend[3] ? r.st_match : r.match;
        n.pready = psel & ~penable;

        // reads; unmapped and reserved locations give zero
        rd_byte = RST_BYTE;
        case (idx)
            IDX_CTRL:     rd_byte = {4'h0, r.pend[0] ? r.st_ctrl : r.ctrl};
            IDX_SYNC:     rd_byte = {7'h0, |r.pend};
            IDX_LEVEL:    rd_byte = {4'h0, r.ilvl};
            IDX_FLAGS:    rd_byte = {6'h0, r.flags};
            IDX_LATCH:    rd_byte = r.latch;
            IDX_DRIFT_CORRECTION:    rd_byte = r.drift_correction;
            IDX_CNT_LO:   rd_byte = r.cnt[7:0];
            IDX_CNT_HI:   rd_byte = r.cnt[15:8];
            IDX_TOP_LO:   rd_byte = top_view[7:0];
            IDX_TOP_HI:   rd_byte = top_view[15:8];
            IDX_MATCH_LO: rd_byte = match_view[7:0];
            IDX_MATCH_HI: rd_byte = match_view[15:8];
            IDX_MASK:     rd_byte = {6'h0, r.mask};
            default:      rd_byte = RST_BYTE;
        endcase
        if (psel & ~penable) begin
            n.prdata = {24'h0, mapped ? rd_byte : RST_BYTE};
        end
        // high byte is caught together with the low byte so the pair is atomic
        if (rd_setup) begin
            case (idx)
                IDX_CNT_LO:   n.latch = r.cnt[15:8];
                IDX_TOP_LO:   n.latch = top_view[15:8];
                IDX_MATCH_LO: n.latch = match_view[15:8];
                default:      n.latch = r.latch;
            endcase
        end

        // writes take effect at the access edge; ctrl, count, top and match are only staged there
        clr = 2'h0;
        if (wr_edge) begin
            case (idx)
                IDX_CTRL: begin
                    n.st_ctrl = wd[3:0];
                    n.pend[0] = 1'b1;
                    n.sync = SYNC_ARMED;
                end
                IDX_LEVEL:    n.ilvl = wd[3:0];
                IDX_FLAGS:    clr = wd[1:0];
                IDX_LATCH:    n.latch = wd;
                IDX_DRIFT_CORRECTION:    n.drift_correction = wd;
                IDX_CNT_LO:   n.latch = wd;
                IDX_TOP_LO:   n.latch = wd;
                IDX_MATCH_LO: n.latch = wd;
                IDX_CNT_HI: begin
                    n.st_cnt = {wd, r.latch};
                    n.pend[1] = 1'b1;
                    n.sync = SYNC_ARMED;
                end
                IDX_TOP_HI: begin
                    n.st_top = {wd, r.latch};
                    n.pend[2] = 1'b1;
                    n.sync = SYNC_ARMED;
                end
                IDX_MATCH_HI: begin
                    n.st_match = {wd, r.latch};
                    n.pend[3] = 1'b1;
                    n.sync = SYNC_ARMED;
                end
                IDX_MASK:     n.mask = wd[1:0];
                default:      n.latch = r.latch;
            endcase
        end

        // sticky flags: a new event wins over a clear in the same cycle
        clr = clr | {match_vector_ack, wrap_vector_ack};
        n.flags = (r.flags & ~clr) | {n.match_evt, n.wrap_evt};
        n.wrap_req = n.flags[FLAG_WRAP] && n.ilvl[1:0] != 2'h0;
        n.match_req = n.flags[FLAG_MATCH] && n.ilvl[3:2] != 2'h0;
        n.irq = |(n.flags & n.mask);
        n.vec = VEC_WRAP;
        if (n.match_req && (!n.wrap_req || n.ilvl[3:2] > n.ilvl[1:0])) begin
            n.vec = VEC_MATCH;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.sync <= SYNC_IDLE;
        end else begin
            r <= n;
        end
    end

    assign prdata          = r.prdata;
    assign pready          = r.pready;
    assign wrap_irq_req    = r.wrap_req;
    assign match_irq_req   = r.match_req;
    assign wrap_irq_level  = r.ilvl[1:0];
    assign match_irq_level = r.ilvl[3:2];
    assign irq_vector      = r.vec;
    assign irq             = r.irq;
    assign wrap_event      = r.wrap_evt;
    assign match_event     = r.match_evt;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_top_write;
        wr_edge && idx == IDX_TOP_HI;
    endsequence
    sequence s_last_rtc;
        r.sync == SYNC_HALF && rtc_tick;
    endsequence
    property p_wrap_flag;
        cnt_tick && wrap_hit |=> r.flags[FLAG_WRAP] && wrap_event;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag not set at top");
    property p_vec_clear;
        r.flags[FLAG_WRAP] && wrap_vector_ack && !(cnt_tick && wrap_hit) |=> !r.flags[FLAG_WRAP];
    endproperty
    a_vec_clear: assert property (p_vec_clear) else $error("vector ack did not clear flag");
    property p_latch_wr;
        wr_edge && idx == IDX_CNT_LO |=> r.latch == $past(pwdata[7:0]);
    endproperty
    a_latch_wr: assert property (p_latch_wr) else $error("low byte write missed latch");
    property p_latch_rd;
        rd_setup && idx == IDX_CNT_LO
            |=> r.latch == $past(r.cnt[15:8]) && prdata[7:0] == $past(r.cnt[7:0]);
    endproperty
    a_latch_rd: assert property (p_latch_rd) else $error("low byte read not paired");
    property p_slow;
        corr_slot && !r.drift_correction[DRIFT_CORRECTION_SIGN_BIT] && r.ctrl[2:0] != PRE_OFF
            |=> r.presc == $past(r.presc) && !wrap_event && !match_event;
    endproperty
    a_slow: assert property (p_slow) else $error("slow-down did not hold prescaler");
    property p_slot_magnitude;
        corr_slot |-> r.corr_act && r.drift_correction[6:0] != 7'h0;
    endproperty
    a_slot_magnitude: assert property (p_slot_magnitude)
        else $error("correction without magnitude");
    property p_inc;
        cnt_tick && !wrap_hit && !sync_apply |=> r.cnt == $past(r.cnt) + 16'h1;
    endproperty
    a_inc: assert property (p_inc) else $error("counter did not increment");
    property p_top_lands;
        s_top_write ##1 (r.sync == SYNC_ARMED && !rtc_tick) |=> r.top == $past(r.top);
    endproperty
    a_top_lands: assert property (p_top_lands) else $error("top applied too early");
    property p_top_apply;
        s_last_rtc and r.pend[2] |=> r.top == $past(r.st_top) && r.pend == 4'h0;
    endproperty
    a_top_apply: assert property (p_top_apply) else $error("top not applied on second rtc cycle");
    property p_wrap_zero;
        cnt_tick && wrap_hit && !(sync_apply && r.pend[1]) |=> r.cnt == RST_WORD;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("counter not cleared at top");
    property p_match;
        cnt_tick && r.cnt == r.match && r.match <= r.top |=> r.flags[FLAG_MATCH] && match_event;
    endproperty
    a_match: assert property (p_match) else $error("match flag not set");
    property p_no_match;
        cnt_tick && r.match > r.top |=> !match_event;
    endproperty
    a_no_match: assert property (p_no_match) else $error("match above top raised event");
    property p_stop;
        r.ctrl[2:0] == PRE_OFF |=> $stable(r.presc) && !wrap_event;
    endproperty
    a_stop: assert property (p_stop) else $error("stopped counter moved");
    property p_busy;
        wr_edge && idx == IDX_CTRL |=> r.pend[0] ##1 (|r.pend) [*2];
    endproperty
    a_busy: assert property (p_busy) else $error("crossing busy not shown");
    property p_req;
        r.wrap_req == (r.flags[FLAG_WRAP] && r.ilvl[1:0] != 2'h0);
    endproperty
    a_req: assert property (p_req) else $error("wrap request mismatch");
    property p_join;
        wr_edge && idx == IDX_CNT_HI |=> r.st_cnt == {$past(pwdata[7:0]), $past(r.latch)};
    endproperty
    a_join: assert property (p_join) else $error("high write did not join latch");

endmodule

`default_nettype wire

// [pkg/rtcb_pkg.sv]
// Purpose: constants and types shared by the real-time counter register bank
// Assumes: register index n sits at byte address 4*n on the apb bus
// Notes:   one clock only; the rtc clock arrives as a sampled pin
`default_nettype none

package rtcb_pkg;

    // register indices (byte address is four times the index)
    localparam logic [3:0] IDX_CTRL     = 4'h0;
    localparam logic [3:0] IDX_SYNC     = 4'h1;
    localparam logic [3:0] IDX_LEVEL    = 4'h2;
    localparam logic [3:0] IDX_FLAGS    = 4'h3;
    localparam logic [3:0] IDX_LATCH    = 4'h4;
    localparam logic [3:0] IDX_DRIFT_CORRECTION    = 4'h6;
    localparam logic [3:0] IDX_CNT_LO   = 4'h8;
    localparam logic [3:0] IDX_CNT_HI   = 4'h9;
    localparam logic [3:0] IDX_TOP_LO   = 4'ha;
    localparam logic [3:0] IDX_TOP_HI   = 4'hb;
    localparam logic [3:0] IDX_MATCH_LO = 4'hc;
    localparam logic [3:0] IDX_MATCH_HI = 4'hd;
    localparam logic [3:0] IDX_MASK     = 4'he;

    // field positions
    localparam int CTRL_CORR_BIT  = 3;
    localparam int DRIFT_CORRECTION_SIGN_BIT = 7;
    localparam int FLAG_WRAP      = 0;
    localparam int FLAG_MATCH     = 1;
    localparam int SYNC_BUSY_BIT  = 0;

    // reset values and codes
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [2:0]  PRE_OFF   = 3'h0;
    localparam logic [7:0]  VEC_WRAP  = 8'h00;
    localparam logic [7:0]  VEC_MATCH = 8'h02;

    // timing: correction interval is 2**20 rtc cycles (about one million)
    localparam int CORR_BITS       = 20;
    localparam int SYNC_RTC_CYCLES = 2;

    // write crossing sequencer
    typedef enum logic [2:0] {
        SYNC_IDLE  = 3'b001,
        SYNC_ARMED = 3'b010,
        SYNC_HALF  = 3'b100
    } rtcb_sync_type;

endpackage

`default_nettype wire

// [tb/rtcb_testbench.sv]
// Purpose: self-checking bench for the real-time counter register bank
// Assumes: zero-wait apb slave, rtc pin toggled every 4 pclk (8 pclk per rtc cycle)
// Notes:   drift correction rate is not timed here; its interval is far too long
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rtcb_pkg::*;

    // clock, reset, bus
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready;
    // rtc pin and interrupt side
    logic        rtc_clk_pin, wrap_vector_ack, match_vector_ack;
    logic        wrap_irq_req, match_irq_req, irq, wrap_event, match_event;
    logic [1:0]  wrap_irq_level, match_irq_level;
    logic [7:0]  irq_vector;
    logic [1:0]  rtc_div;
    int          mismatches, tests_run;

    rtcb_core rtcb_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .rtc_clk_pin(rtc_clk_pin), .wrap_vector_ack(wrap_vector_ack),
        .match_vector_ack(match_vector_ack), .wrap_irq_req(wrap_irq_req),
        .match_irq_req(match_irq_req), .wrap_irq_level(wrap_irq_level),
        .match_irq_level(match_irq_level), .irq_vector(irq_vector), .irq(irq),
        .wrap_event(wrap_event), .match_event(match_event));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // free-running rtc pin, exact period keeps tick spacing predictable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_div     <= 2'h0;
            rtc_clk_pin <= 1'b0;
        end else begin
            rtc_div     <= rtc_div + 2'h1;
            rtc_clk_pin <= (rtc_div == 2'h3) ? ~rtc_clk_pin : rtc_clk_pin;
        end
    end

    function automatic logic [7:0] ad(input logic [3:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // read before this edge's updates land, so these are the sampled values
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) check("pready", 16'h0, 16'h1);
        q = prdata[7:0];
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        apb(1'b0, a, 8'h00, q);
        check(nm, {8'h00, q}, {8'h00, exp});
    endtask

    task automatic wait_idle();
        logic [7:0] q;
        int         n;
        n = 0;
        do begin
            apb(1'b0, ad(IDX_SYNC), 8'h00, q);
            n++;
        end while (q[SYNC_BUSY_BIT] !== 1'b0 && n < 50);
        check("crossing_pending", {15'h0, q[SYNC_BUSY_BIT]}, 16'h0);
    endtask

    task automatic wait_wrap(output int cyc);
        cyc = 0;
        do begin
            @(negedge pclk);
            cyc++;
        end while (wrap_event !== 1'b1 && cyc < 5000);
    endtask

    task automatic t_reset_map();
        logic [7:0] addrs [16] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                                   8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};
        foreach (addrs[i]) rd_chk("reset value", addrs[i], RST_BYTE);
        wr(8'h14, 8'hff);
        wr(8'h40, 8'hff);
        rd_chk("reserved", 8'h14, 8'h00);
        rd_chk("unmapped", 8'h40, 8'h00);
    endtask

    task automatic t_regs();
        wr(ad(IDX_DRIFT_CORRECTION), 8'h85);
        rd_chk("drift_correction", ad(IDX_DRIFT_CORRECTION), 8'h85);
        wr(ad(IDX_DRIFT_CORRECTION), 8'h00); // no speed-up sign while divide-by-one is used
        wr(ad(IDX_CTRL), 8'hf0);
        rd_chk("crossing busy", ad(IDX_SYNC), 8'h01);
        rd_chk("control reserved", ad(IDX_CTRL), 8'h00);
        wait_idle();
        wr(ad(IDX_LEVEL), 8'hf9);
        rd_chk("irq_level_select", ad(IDX_LEVEL), 8'h09);
        check("irq levels", {12'h0, match_irq_level, wrap_irq_level}, 16'h0009);
    endtask

    // counter stopped, so the written value must hold still
    task automatic t_pair();
        wr(ad(IDX_CNT_LO), 8'h34);
        rd_chk("latch after low write", ad(IDX_LATCH), 8'h34);
        wr(ad(IDX_CNT_HI), 8'h12);
        wait_idle();
        repeat (100) @(posedge pclk);
        rd_chk("count_low", ad(IDX_CNT_LO), 8'h34);
        rd_chk("latch after low read", ad(IDX_LATCH), 8'h12);
        rd_chk("count_high", ad(IDX_CNT_HI), 8'h12);
    endtask

    task automatic set16(input logic [3:0] lo, input logic [15:0] v);
        wait_idle();
        wr(ad(lo), v[7:0]);
        wr(ad(lo + 4'h1), v[15:8]);
    endtask

    task automatic t_flags();
        int n;
        set16(IDX_CNT_LO, 16'h0000);
        set16(IDX_TOP_LO, 16'h0005);
        set16(IDX_MATCH_LO, 16'h0003);
        wr(ad(IDX_MASK), 8'h03);
        wr(ad(IDX_CTRL), 8'h01);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (wrap_irq_req !== 1'b1 && n < 400);
        check("wrap request", {15'h0, wrap_irq_req}, 16'h1);
        wr(ad(IDX_CTRL), 8'h00);
        wait_idle();
        rd_chk("both flags", ad(IDX_FLAGS), 8'h03);
        @(negedge pclk);
        check("irq", {15'h0, irq}, 16'h1);
        check("match request", {15'h0, match_irq_req}, 16'h1);
        check("vector", {8'h0, irq_vector}, {8'h0, VEC_MATCH});
        wr(ad(IDX_MASK), 8'h00);
        @(negedge pclk);
        check("masked irq", {15'h0, irq}, 16'h0);
        wr(ad(IDX_MASK), 8'h03);
        @(posedge pclk);
        match_vector_ack <= 1'b1;
        @(posedge pclk);
        match_vector_ack <= 1'b0;
        rd_chk("after match ack", ad(IDX_FLAGS), 8'h01);
        @(negedge pclk);
        check("vector", {8'h0, irq_vector}, {8'h0, VEC_WRAP});
        @(posedge pclk);
        wrap_vector_ack <= 1'b1;
        @(posedge pclk);
        wrap_vector_ack <= 1'b0;
        rd_chk("after wrap ack", ad(IDX_FLAGS), 8'h00);
        @(negedge pclk);
        check("irq cleared", {14'h0, irq, wrap_irq_req}, 16'h0);
    endtask

    task automatic t_above();
        int hits;
        set16(IDX_MATCH_LO, 16'h0009);
        wr(ad(IDX_CTRL), 8'h01);
        hits = 0;
        repeat (400) begin
            @(negedge pclk);
            if (match_event === 1'b1) hits++;
        end
        check("match events", 16'(hits), 16'h0);
        wr(ad(IDX_CTRL), 8'h00);
        wait_idle();
        rd_chk("only wrap flag", ad(IDX_FLAGS), 8'h01);
        wr(ad(IDX_FLAGS), 8'h03);
        rd_chk("after clear", ad(IDX_FLAGS), 8'h00);
    endtask

    // wrap spacing is (top+1) * divide * 8 pclk with top = 3
    task automatic t_rate();
        int div [5] = '{1, 2, 8, 16, 64};
        int c;
        set16(IDX_CNT_LO, 16'h0000);
        set16(IDX_TOP_LO, 16'h0003);
        foreach (div[i]) begin
            wr(ad(IDX_CTRL), 8'(i + 1));
            wait_idle();
            wait_wrap(c);
            wait_wrap(c);
            check("wrap spacing", 16'(c), 16'(32 * div[i]));
        end
        wr(ad(IDX_CTRL), {5'h0, PRE_OFF});
        wait_idle();
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        mismatches = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wrap_vector_ack = 1'b0;
        match_vector_ack = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_map();
        t_regs();
        t_pair();
        t_flags();
        t_above();
        t_rate();
        summarize();
    end

    // whole run needs roughly 7k cycles
    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        summarize();
    end
endmodule

`default_nettype wire
